//--- shared/sssr_map.svh
// Register map, field positions, reset values and timing figures of the slave supervisor
`ifndef SSSR_MAP_SVH
`define SSSR_MAP_SVH

// Register byte offsets
`define SSSR_OFF_CTRL        8'h00
`define SSSR_OFF_STATUS      8'h04
`define SSSR_OFF_NVM_WR      8'h08
`define SSSR_OFF_SHADOW_LO   8'h0c
`define SSSR_OFF_SHADOW_HI   8'h10

// Control fields and reset value
`define SSSR_CTRL_WDOG_DIS   0
`define SSSR_CTRL_EXT_MODE   1
`define SSSR_CTRL_RESET      2'h2

// Status fields
`define SSSR_ST_STATE_LSB    0
`define SSSR_ST_ADDR_OK      5
`define SSSR_ST_NVM_BUSY     6
`define SSSR_ST_WDOG_FIRED   7
`define SSSR_ST_POWERED      8
`define SSSR_ST_EXT_RST      9

// Memory write request fields
`define SSSR_NVW_DATA_MSB    7
`define SSSR_NVW_ADDR_LSB    8
`define SSSR_NVW_ADDR_MSB    11

// Memory locations
`define SSSR_NV_ADDR_A       4'h0
`define SSSR_NV_ADDR_B       4'h1
`define SSSR_NV_EXT_ONE      4'h2
`define SSSR_NV_IO_CFG       4'h3
`define SSSR_NV_IDENT        4'h4
`define SSSR_NV_EXT_TWO      4'h5
`define SSSR_NV_CTRL_CODE    4'h6
`define SSSR_NV_DEPTH        16

// Request frame layout and select bit
`define SSSR_REQ_ST          13
`define SSSR_REQ_CB          12
`define SSSR_REQ_A_MSB       11
`define SSSR_REQ_A_LSB       7
`define SSSR_REQ_I_MSB       6
`define SSSR_REQ_I_LSB       2
`define SSSR_REQ_PB          1
`define SSSR_REQ_EB          0
`define SSSR_SEL_BIT         3

// Commands
`define SSSR_CMD_RESET_SLAVE  5'h1c
`define SSSR_CMD_GLOBAL_RESET 5'h15
`define SSSR_BCAST_ADDR       5'h1f

// Bus answers
`define SSSR_RESP_OKAY       2'h0
`define SSSR_RESP_SLVERR     2'h2

// Timing
`define SSSR_CLK_KHZ         200000
`define SSSR_CLK_PERIOD_PS   5000
`define SSSR_T_WDOG_MS       80
`define SSSR_T_EXTRST_MS     100
`define SSSR_T_NORESET_MS    50
`define SSSR_T_PULSE_NS      6000
`define SSSR_T_BLINK_HALF_MS 200
`define SSSR_T_NVM_WR_MS     10
`define SSSR_T_NVM_RD_US     500

`endif

//--- shared/sssr_pkg.sv
// Types of the slave supervisor
package sssr_pkg;

  typedef enum logic [4:0] {
    ST_REGULAR = 5'b00001,
    ST_NO_COMM = 5'b00010,
    ST_NO_ADDR = 5'b00100,
    ST_FAULT   = 5'b01000,
    ST_EXT_RST = 5'b10000
  } sssr_state_t;

  typedef enum logic [2:0] {
    NV_IDLE  = 3'b001,
    NV_LOAD  = 3'b010,
    NV_WRITE = 3'b100
  } sssr_nv_t;

  typedef struct packed {
    logic       cb;
    logic [4:0] addr;
    logic [4:0] info;
  } sssr_req_t;

  typedef struct packed {
    logic green;
    logic red;
  } sssr_led_t;

endpackage

//--- testbench/sssr_master.sv
// Bus master model sending request frames
`timescale 1ns/1ps
module sssr_master (
  // Bus side
  input wire logic        MCLK,
  output logic            RX_FRAME_VALID,
  output logic [13:0]     RX_FRAME
);
  initial begin
    RX_FRAME_VALID = 1'b0;
    RX_FRAME = 14'h0;
  end
  task automatic send(input logic cb, input logic [4:0] a, input logic [4:0] i, input logic bad);
    @(posedge MCLK);
    RX_FRAME_VALID <= 1'b1;
    RX_FRAME <= {1'b0, cb, a, i, ^{cb, a, i, bad}, 1'b1};
    @(posedge MCLK);
    RX_FRAME_VALID <= 1'b0;
    RX_FRAME <= ~RX_FRAME;
  endtask
endmodule // sssr_master

//--- testbench/sssr_props.sv
// Port assertions of the slave supervisor
`timescale 1ns/1ps
module sssr_props (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // Supply pins
  input wire logic        CORE_SUPPLY_OK,
  input wire logic        FIELD_OVERLOAD,
  // Strobes, indicator and reset effects
  input wire logic        DATA_STROBE_N_OE,
  input wire logic        PARAM_STROBE_N_OE,
  input wire logic        SOFT_RESET,
  input wire logic        PORT_OUT_OFF,
  input wire logic        RX_DESYNC,
  input wire logic        TEST_MODE_CANCEL,
  input wire logic        STATUS_IND_GREEN_OE,
  // Frames
  input wire logic        RX_FRAME_VALID,
  input wire logic [13:0] RX_FRAME,
  input wire logic        TX_FRAME_VALID,
  input wire logic [6:0]  TX_FRAME
);
  logic [10:0] low_cnt;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Length of the current strobe pulse
  always_ff @(posedge MCLK) low_cnt <= DATA_STROBE_N_OE ? low_cnt + 11'h1 : 11'h0;
  property p_soft_oe; SOFT_RESET |-> DATA_STROBE_N_OE && PARAM_STROBE_N_OE && PORT_OUT_OFF; endproperty
  a_soft_oe: assert property (p_soft_oe) else $error("soft reset without pulse");
  property p_soft_one; SOFT_RESET |=> !SOFT_RESET; endproperty
  a_soft_one: assert property (p_soft_one) else $error("soft reset too long");
  property p_pulse_start; $rose(PARAM_STROBE_N_OE) |-> SOFT_RESET; endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("stray strobe pulse");
  property p_pulse_len; $fell(DATA_STROBE_N_OE) |-> low_cnt == 11'h4b0; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("strobe pulse length wrong");
  property p_tx_form; TX_FRAME_VALID |-> !TX_FRAME[6] && TX_FRAME[0] && !(^TX_FRAME[5:1]); endproperty
  a_tx_form: assert property (p_tx_form) else $error("bad response framing");
  property p_bad_par; RX_FRAME_VALID && ^RX_FRAME[12:1] |=> !TX_FRAME_VALID; endproperty
  a_bad_par: assert property (p_bad_par) else $error("answer to bad parity");
  property p_overload; FIELD_OVERLOAD [*6] |-> !STATUS_IND_GREEN_OE; endproperty
  a_overload: assert property (p_overload) else $error("green lit in overload");
  property p_hard; !CORE_SUPPLY_OK [*6] |-> RX_DESYNC && TEST_MODE_CANCEL && PORT_OUT_OFF; endproperty
  a_hard: assert property (p_hard) else $error("no hard reset on core drop");
endmodule // sssr_props

bind sssr_top sssr_props i_props (.*);

//--- testbench/sssr_top_bench.sv
// Self-checking bench of the slave supervisor
`timescale 1ns/1ps
`include "sssr_map.svh"
module sssr_top_bench;
  logic MCLK, RST_N, CORE_SUPPLY_OK, FIELD_SUPPLY_OK, FIELD_OVERLOAD, PERIPH_FAULT_N, ds_pull;
  logic DATA_STROBE_N_I, DATA_STROBE_N_O, DATA_STROBE_N_OE, PARAM_STROBE_N_I, PARAM_STROBE_N_O;
  logic PARAM_STROBE_N_OE, STATUS_IND_GREEN_O, STATUS_IND_GREEN_OE, STATUS_IND_RED_O, STATUS_IND_RED_OE;
  logic RX_FRAME_VALID, TX_FRAME_VALID, REQ_VALID, REQ_CB, RX_DESYNC, PORT_OUT_OFF, TEST_MODE_CANCEL;
  logic SOFT_RESET, COMM_ABORT, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [13:0] RX_FRAME;
  logic [6:0]  TX_FRAME;
  logic [4:0]  REQ_INFO;
  logic [3:0]  RESP_INFO, S_AXI_WSTRB;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rrsp;
  int          n_fail, samples_checked;
  // Open-drain strobe wires with pull-up
  assign DATA_STROBE_N_I = !(DATA_STROBE_N_OE | ds_pull);
  assign PARAM_STROBE_N_I = !PARAM_STROBE_N_OE;
  sssr_top #(.WDOG_CYC(200), .EXTRST_CYC(400), .BLINK_CYC(50), .NVM_WR_CYC(30), .NVM_RD_CYC(5)) i_dut (.*);
  sssr_master i_mst (.*);
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  task give_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    rrsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    S_AXI_ARVALID <= 1'b1;
    S_AXI_ARADDR <= a;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    rdat = S_AXI_RDATA;
    rrsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask
  // Soft reset seen within n cycles or not
  task sw(input logic e, input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge MCLK);
      s = s | SOFT_RESET;
    end
    chk(s, e);
  endtask
  task fr(input logic cb, input logic [4:0] a, input logic [4:0] i, input logic bad, input logic hit);
    i_mst.send(cb, a, i, bad);
    #1;
    chk({TX_FRAME_VALID, REQ_VALID}, {hit, hit});
    if (hit) chk({TX_FRAME, REQ_CB, REQ_INFO}, {1'b0, RESP_INFO, ^RESP_INFO, 1'b1, cb, i});
  endtask
  initial begin
    #150us;
    n_fail++;
    give_verdict;
  end
  initial begin
    {RST_N, FIELD_SUPPLY_OK, FIELD_OVERLOAD, ds_pull, S_AXI_AWVALID, S_AXI_WVALID} = 6'h0;
    {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 51'h0;
    {CORE_SUPPLY_OK, PERIPH_FAULT_N, RESP_INFO, S_AXI_WSTRB} = 10'h33f;
    n_fail = 0;
    samples_checked = 0;
    cyc(20);
    RST_N <= 1'b1;
    rc(`SSSR_OFF_CTRL, 32'hffffffff, 32'h2);
    rd(8'h14);
    chk(rrsp, `SSSR_RESP_SLVERR);
    wr(`SSSR_OFF_STATUS, 32'h1f);
    chk(rrsp, `SSSR_RESP_SLVERR);
    rc(`SSSR_OFF_STATUS, 32'h100, 32'h0);
    FIELD_SUPPLY_OK <= 1'b1;
    cyc(50);
    rc(`SSSR_OFF_STATUS, 32'h100, 32'h100);
    wr(`SSSR_OFF_CTRL, 32'h3);
    wr(`SSSR_OFF_NVM_WR, 32'h005);
    cyc(40);
    wr(`SSSR_OFF_NVM_WR, 32'h106);
    cyc(40);
    rc(`SSSR_OFF_STATUS, 32'h3f, 32'h04);
    chk(STATUS_IND_RED_OE, 1'b1);
    wr(`SSSR_OFF_NVM_WR, 32'h105);
    cyc(40);
    rc(`SSSR_OFF_STATUS, 32'h3f, 32'h21);
    chk({STATUS_IND_GREEN_OE, STATUS_IND_RED_OE}, 2'b10);
    fr(1'b0, 5'h05, 5'h02, 1'b0, 1'b1);
    fr(1'b0, 5'h05, 5'h08, 1'b0, 1'b0);
    fr(1'b0, 5'h05, 5'h02, 1'b1, 1'b0);
    // Plain mode: command bit 3 is no select bit
    wr(`SSSR_OFF_CTRL, 32'h1);
    i_mst.send(1'b1, 5'h05, `SSSR_CMD_RESET_SLAVE, 1'b0);
    sw(1'b1, 10);
    cyc(1300);
    rc(`SSSR_OFF_SHADOW_LO, 32'hffff, 32'h0505);
    fr(1'b1, `SSSR_BCAST_ADDR, `SSSR_CMD_GLOBAL_RESET, 1'b0, 1'b0);
    sw(1'b1, 10);
    cyc(1300);
    ds_pull <= 1'b1;
    cyc(150);
    ds_pull <= 1'b0;
    sw(1'b0, 500);
    ds_pull <= 1'b1;
    sw(1'b1, 500);
    rc(`SSSR_OFF_STATUS, 32'h1f, 32'h10);
    chk(STATUS_IND_GREEN_OE, 1'b0);
    ds_pull <= 1'b0;
    cyc(1300);
    PERIPH_FAULT_N <= 1'b0;
    cyc(60);
    chk(STATUS_IND_GREEN_OE ^ STATUS_IND_RED_OE, 1'b1);
    rc(`SSSR_OFF_STATUS, 32'h1f, 32'h08);
    PERIPH_FAULT_N <= 1'b1;
    FIELD_OVERLOAD <= 1'b1;
    cyc(10);
    rc(`SSSR_OFF_STATUS, 32'h1f, 32'h10);
    FIELD_OVERLOAD <= 1'b0;
    ds_pull <= 1'b1;
    cyc(5);
    ds_pull <= 1'b0;
    wr(`SSSR_OFF_CTRL, 32'h2);
    sw(1'b1, 300);
    rc(`SSSR_OFF_STATUS, 32'h9f, 32'h82);
    chk({STATUS_IND_GREEN_OE, STATUS_IND_RED_OE}, 2'b00);
    wr(`SSSR_OFF_CTRL, 32'h3);
    cyc(1300);
    FIELD_SUPPLY_OK <= 1'b0;
    cyc(8);
    chk({COMM_ABORT, RX_DESYNC}, 2'b10);
    CORE_SUPPLY_OK <= 1'b0;
    cyc(8);
    chk(RX_DESYNC, 1'b1);
    give_verdict;
  end
endmodule // sssr_top_bench

//--- verilog/sssr_top.sv
// Supervisor of a field-bus slave: indicators, watchdog, resets, setup memory, framing
//
// Operation
// - Watchdog fired, valid address: both indicators off
// - Address zero: green blinks, red on
// - Peripheral fault low: green and red alternate
// - External reset or overload: green off, red blinks
// - Strobe silence over window starts soft reset
// - Hard reset until both supplies good
// - Core supply drop forces hard reset
// - Data strobe held low 100 ms: soft reset
// - Reset-slave or global reset command: soft reset
// - Hard reset clears, desyncs, ports off, test off
// - Soft reset: 6 us strobe pulse, clears state
// - Soft reset spares blink, bus, test, write
// - Field drop aborts bus, no hard reset
// - Reset copies memory into shadow registers
// - Address copies differ: treat as zero
// - Memory accessed bytewise, 10 ms write, read
// - Address six bits extended, five otherwise
// - Control bit selects data or command
// - Extended mode: I3 selects A or B
// - Seven-bit response frame sent back
// - Strobe low up to 50 ms ignored
`timescale 1ns/1ps
`include "sssr_map.svh"

module sssr_top #(
  parameter int unsigned WDOG_CYC   = `SSSR_T_WDOG_MS * `SSSR_CLK_KHZ,
  parameter int unsigned EXTRST_CYC = `SSSR_T_EXTRST_MS * `SSSR_CLK_KHZ,
  parameter int unsigned BLINK_CYC  = `SSSR_T_BLINK_HALF_MS * `SSSR_CLK_KHZ,
  parameter int unsigned NVM_WR_CYC = `SSSR_T_NVM_WR_MS * `SSSR_CLK_KHZ,
  parameter int unsigned NVM_RD_CYC = `SSSR_T_NVM_RD_US * `SSSR_CLK_KHZ / 1000
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // Supply and fault pins
  input  wire logic        CORE_SUPPLY_OK,
  input  wire logic        FIELD_SUPPLY_OK,
  input  wire logic        FIELD_OVERLOAD,
  input  wire logic        PERIPH_FAULT_N,
  // Strobe pins
  input  wire logic        DATA_STROBE_N_I,
  output logic             DATA_STROBE_N_O,
  output logic             DATA_STROBE_N_OE,
  input  wire logic        PARAM_STROBE_N_I,
  output logic             PARAM_STROBE_N_O,
  output logic             PARAM_STROBE_N_OE,
  // Indicator pins
  output logic             STATUS_IND_GREEN_O,
  output logic             STATUS_IND_GREEN_OE,
  output logic             STATUS_IND_RED_O,
  output logic             STATUS_IND_RED_OE,
  // Bus frames from and to the modem
  input  wire logic        RX_FRAME_VALID,
  input  wire logic [13:0] RX_FRAME,
  input  wire logic [3:0]  RESP_INFO,
  output logic             TX_FRAME_VALID,
  output logic [6:0]       TX_FRAME,
  // Decoded request to the port logic
  output logic             REQ_VALID,
  output logic             REQ_CB,
  output logic [4:0]       REQ_INFO,
  // Reset effects
  output logic             RX_DESYNC,
  output logic             PORT_OUT_OFF,
  output logic             TEST_MODE_CANCEL,
  output logic             SOFT_RESET,
  output logic             COMM_ABORT,
  // AXI4-Lite slave
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);

  localparam int unsigned PULSE_CYC = `SSSR_T_PULSE_NS * 1000 / `SSSR_CLK_PERIOD_PS;
  localparam int unsigned NSYNC     = 6;
  localparam logic [5:0]  SYNC_RST  = 6'h30;

  // Pin synchronisers: strobes idle high, supplies and fault idle low
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {DATA_STROBE_N_I, PARAM_STROBE_N_I, CORE_SUPPLY_OK,
                    FIELD_SUPPLY_OK, FIELD_OVERLOAD, PERIPH_FAULT_N};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic dstb_n;
  logic pstb_n;
  logic core_ok;
  logic field_ok;
  logic overload;
  logic fault_n;
  assign {dstb_n, pstb_n, core_ok, field_ok, overload, fault_n} = sync2_reg;

  // Hard reset
  logic powered_reg;
  logic hard_rst;
  always_ff @(posedge MCLK) begin
    if (!RST_N || !core_ok) begin
      powered_reg <= 1'b0;
    end else if (field_ok) begin
      powered_reg <= 1'b1;
    end
  end
  assign hard_rst = !RST_N || !core_ok || !powered_reg;

  // Strobe edges, masked during our own reset pulse
  logic               dstb_prev_reg;
  logic               pstb_prev_reg;
  logic               pulse_act_reg;
  logic [31:0]        pulse_cnt_reg;
  logic               strobe_seen;
  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      dstb_prev_reg <= 1'b1;
      pstb_prev_reg <= 1'b1;
    end else begin
      dstb_prev_reg <= dstb_n;
      pstb_prev_reg <= pstb_n;
    end
  end
  assign strobe_seen = !pulse_act_reg && ((dstb_prev_reg && !dstb_n) || (pstb_prev_reg && !pstb_n));

  // Soft reset sources
  logic               sr_hold;
  logic               sr_wdog;
  logic               sr_cmd;
  logic               soft_evt;
  assign soft_evt = !hard_rst && (sr_hold || sr_wdog || sr_cmd);

  // Data strobe hold detector; not cleared by soft reset so one hold gives one reset
  logic [31:0]        low_cnt_reg;
  logic               ext_rst_reg;
  always_ff @(posedge MCLK) begin
    if (hard_rst || dstb_n) begin
      low_cnt_reg <= 32'h0;
      ext_rst_reg <= 1'b0;
    end else if (low_cnt_reg == EXTRST_CYC) begin
      ext_rst_reg <= 1'b1;
    end else if (!pulse_act_reg) begin
      low_cnt_reg <= low_cnt_reg + 32'h1;  // Own pulse does not count
    end
  end
  assign sr_hold = !dstb_n && !pulse_act_reg && (low_cnt_reg == EXTRST_CYC - 1);

  // Communication watchdog
  logic               wd_armed_reg;
  logic [31:0]        wd_cnt_reg;
  logic               wd_fired_reg;
  logic [1:0]         ctrl_reg;
  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      wd_armed_reg <= 1'b0;
      wd_cnt_reg   <= 32'h0;
      wd_fired_reg <= 1'b0;
    end else if (strobe_seen) begin
      wd_armed_reg <= 1'b1;
      wd_cnt_reg   <= 32'h0;
      wd_fired_reg <= 1'b0;
    end else if (sr_wdog) begin
      wd_armed_reg <= 1'b0;
      wd_cnt_reg   <= 32'h0;
      wd_fired_reg <= 1'b1;
    end else if (soft_evt) begin
      wd_armed_reg <= 1'b0;
      wd_cnt_reg   <= 32'h0;
    end else if (wd_armed_reg && !ctrl_reg[`SSSR_CTRL_WDOG_DIS]) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end
  assign sr_wdog = wd_armed_reg && !ctrl_reg[`SSSR_CTRL_WDOG_DIS] && !strobe_seen
                   && (wd_cnt_reg == WDOG_CYC - 1);

  // Soft reset strobe pulse on both strobe pins
  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      pulse_act_reg <= 1'b0;
      pulse_cnt_reg <= 32'h0;
    end else if (soft_evt) begin
      pulse_act_reg <= 1'b1;
      pulse_cnt_reg <= 32'h0;
    end else if (pulse_act_reg) begin
      pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
      if (pulse_cnt_reg == PULSE_CYC - 1) begin
        pulse_act_reg <= 1'b0;
      end
    end
  end

  // Reset effect outputs
  always_ff @(posedge MCLK) begin
    DATA_STROBE_N_O   <= 1'b0;
    PARAM_STROBE_N_O  <= 1'b0;
    DATA_STROBE_N_OE  <= !hard_rst && (soft_evt || pulse_act_reg) && !(pulse_act_reg
                         && pulse_cnt_reg == PULSE_CYC - 1);
    PARAM_STROBE_N_OE <= !hard_rst && (soft_evt || pulse_act_reg) && !(pulse_act_reg
                         && pulse_cnt_reg == PULSE_CYC - 1);
    RX_DESYNC         <= hard_rst;
    TEST_MODE_CANCEL  <= hard_rst;
    PORT_OUT_OFF      <= hard_rst || soft_evt;
    SOFT_RESET        <= soft_evt;
    COMM_ABORT        <= !hard_rst && !field_ok;
  end

  // Setup memory and shadow copies
  logic [7:0]         nvm_mem [0:`SSSR_NV_DEPTH-1];
  logic [7:0]         shadow_reg [0:6];
  sssr_pkg::sssr_nv_t nv_state_reg;
  logic [3:0]         nv_idx_reg;
  logic [7:0]         nv_data_reg;
  logic [31:0]        nv_cnt_reg;
  logic               load_pend_reg;
  logic               nv_wr_req;
  logic [3:0]         nv_wr_addr;
  logic [7:0]         nv_wr_data;

  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      nv_state_reg  <= sssr_pkg::NV_LOAD;
      nv_idx_reg    <= `SSSR_NV_ADDR_A;
      nv_data_reg   <= 8'h00;
      nv_cnt_reg    <= 32'h0;
      load_pend_reg <= 1'b0;
    end else begin
      case (nv_state_reg)
        sssr_pkg::NV_IDLE: begin
          nv_cnt_reg <= 32'h0;
          if (soft_evt || load_pend_reg) begin
            nv_state_reg  <= sssr_pkg::NV_LOAD;
            nv_idx_reg    <= `SSSR_NV_ADDR_A;
            load_pend_reg <= 1'b0;
          end else if (nv_wr_req) begin
            nv_state_reg <= sssr_pkg::NV_WRITE;
            nv_idx_reg   <= nv_wr_addr;
            nv_data_reg  <= nv_wr_data;
          end
        end
        sssr_pkg::NV_LOAD: begin
          if (soft_evt) begin
            nv_idx_reg <= `SSSR_NV_ADDR_A;
            nv_cnt_reg <= 32'h0;
          end else if (nv_cnt_reg == NVM_RD_CYC - 1) begin
            nv_cnt_reg <= 32'h0;
            if (nv_idx_reg == `SSSR_NV_CTRL_CODE) begin
              nv_state_reg <= sssr_pkg::NV_IDLE;
            end else begin
              nv_idx_reg <= nv_idx_reg + 4'h1;
            end
          end else begin
            nv_cnt_reg <= nv_cnt_reg + 32'h1;
          end
        end
        sssr_pkg::NV_WRITE: begin
          if (soft_evt) begin
            load_pend_reg <= 1'b1;
          end
          if (nv_cnt_reg == NVM_WR_CYC - 1) begin
            nv_cnt_reg   <= 32'h0;
            nv_state_reg <= sssr_pkg::NV_IDLE;
          end else begin
            nv_cnt_reg <= nv_cnt_reg + 32'h1;
          end
        end
        default: begin
          nv_state_reg <= sssr_pkg::NV_IDLE;
        end
      endcase
    end
  end

  // Memory array keeps its contents through every reset
  always_ff @(posedge MCLK) begin
    if (!hard_rst && nv_state_reg == sssr_pkg::NV_WRITE && nv_cnt_reg == NVM_WR_CYC - 1) begin
      nvm_mem[nv_idx_reg] <= nv_data_reg;
    end
  end

  generate
    for (gi = 0; gi < 7; gi++) begin : g_shadow
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          shadow_reg[gi] <= 8'h00;
        end else if (nv_state_reg == sssr_pkg::NV_LOAD && nv_idx_reg == 4'(gi) && !soft_evt
                     && nv_cnt_reg == NVM_RD_CYC - 1) begin
          shadow_reg[gi] <= nvm_mem[gi];
        end else if (nv_wr_req && nv_state_reg == sssr_pkg::NV_IDLE && nv_wr_addr == 4'(gi)) begin
          shadow_reg[gi] <= nv_wr_data;
        end
      end
    end
  endgenerate

  // Effective slave address
  logic               addr_ok;
  logic [5:0]         eff_addr;
  logic               ext_mode;
  assign ext_mode = ctrl_reg[`SSSR_CTRL_EXT_MODE];
  assign addr_ok  = ext_mode ? (shadow_reg[0][5:0] == shadow_reg[1][5:0])
                             : (shadow_reg[0][4:0] == shadow_reg[1][4:0]);
  assign eff_addr = !addr_ok ? 6'h00 : ext_mode ? shadow_reg[0][5:0]
                             : {1'b0, shadow_reg[0][4:0]};

  // Request decode and response
  sssr_pkg::sssr_req_t req;
  logic               frame_ok;
  logic               hit;
  assign req      = RX_FRAME[`SSSR_REQ_CB:`SSSR_REQ_I_LSB];
  assign frame_ok = RX_FRAME_VALID && !hard_rst && field_ok && !RX_FRAME[`SSSR_REQ_ST]
                    && RX_FRAME[`SSSR_REQ_EB] && (^{req, RX_FRAME[`SSSR_REQ_PB]} == 1'b0);
  assign hit      = (req.addr == eff_addr[4:0])
                    && (!ext_mode || req.info[`SSSR_SEL_BIT] == eff_addr[5]);
  assign sr_cmd   = frame_ok && req.cb && ((hit && req.info == `SSSR_CMD_RESET_SLAVE)
                    || (req.addr == `SSSR_BCAST_ADDR && req.info == `SSSR_CMD_GLOBAL_RESET));

  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      TX_FRAME_VALID <= 1'b0;
      TX_FRAME       <= 7'h01;
      REQ_VALID      <= 1'b0;
      REQ_CB         <= 1'b0;
      REQ_INFO       <= 5'h00;
    end else begin
      TX_FRAME_VALID <= frame_ok && hit;
      if (frame_ok && hit) begin
        TX_FRAME <= {1'b0, RESP_INFO, ^RESP_INFO, 1'b1};
        REQ_CB   <= req.cb;
        REQ_INFO <= req.info;
      end
      REQ_VALID <= frame_ok && hit;
    end
  end

  // Indicator state and shared blink timer
  sssr_pkg::sssr_state_t st;
  sssr_pkg::sssr_led_t   led;
  logic [31:0]        blink_cnt_reg;
  logic               blink_reg;
  always_ff @(posedge MCLK) begin
    if (hard_rst) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == BLINK_CYC - 1) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  always_comb begin
    if (ext_rst_reg || overload) begin
      st  = sssr_pkg::ST_EXT_RST;
      led = '{green: 1'b0, red: blink_reg};
    end else if (!fault_n) begin
      st  = sssr_pkg::ST_FAULT;
      led = '{green: blink_reg, red: !blink_reg};
    end else if (eff_addr == 6'h00) begin
      st  = sssr_pkg::ST_NO_ADDR;
      led = '{green: blink_reg, red: 1'b1};
    end else if (wd_fired_reg) begin
      st  = sssr_pkg::ST_NO_COMM;
      led = '{green: 1'b0, red: 1'b0};
    end else begin
      st  = sssr_pkg::ST_REGULAR;
      led = '{green: 1'b1, red: 1'b0};
    end
  end

  // Open-drain indicator drive: lit means pulled low
  always_ff @(posedge MCLK) begin
    STATUS_IND_GREEN_O  <= 1'b0;
    STATUS_IND_RED_O    <= 1'b0;
    STATUS_IND_GREEN_OE <= !hard_rst && led.green;
    STATUS_IND_RED_OE   <= !hard_rst && led.red;
  end

  // AXI4-Lite write channel
  logic               aw_have_reg;
  logic               w_have_reg;
  logic [7:0]         aw_addr_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               do_write;
  assign do_write   = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  assign nv_wr_req  = do_write && aw_addr_reg == `SSSR_OFF_NVM_WR && w_strb_reg[1:0] == 2'h3;
  assign nv_wr_addr = w_data_reg[`SSSR_NVW_ADDR_MSB:`SSSR_NVW_ADDR_LSB];
  assign nv_wr_data = w_data_reg[`SSSR_NVW_DATA_MSB:0];

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SSSR_RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= `SSSR_CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg   <= 1'b1;
        aw_addr_reg   <= {S_AXI_AWADDR[7:2], 2'h0};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= S_AXI_WDATA;
        w_strb_reg   <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        case (aw_addr_reg)
          `SSSR_OFF_CTRL: begin
            S_AXI_BRESP <= `SSSR_RESP_OKAY;
            if (w_strb_reg[0]) begin
              ctrl_reg <= w_data_reg[1:0];
            end
          end
          `SSSR_OFF_NVM_WR: begin
            S_AXI_BRESP <= `SSSR_RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP <= `SSSR_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0]        rd_word;
  logic               rd_hit;
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'h0})
      `SSSR_OFF_CTRL:      rd_word = {30'h0, ctrl_reg};
      `SSSR_OFF_STATUS:    rd_word = {22'h0, ext_rst_reg, powered_reg, wd_fired_reg,
                                      nv_state_reg != sssr_pkg::NV_IDLE, addr_ok, st};
      `SSSR_OFF_NVM_WR:    rd_word = 32'h0;
      `SSSR_OFF_SHADOW_LO: rd_word = {shadow_reg[3], shadow_reg[2], shadow_reg[1], shadow_reg[0]};
      `SSSR_OFF_SHADOW_HI: rd_word = {8'h00, shadow_reg[6], shadow_reg[5], shadow_reg[4]};
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `SSSR_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= rd_hit ? `SSSR_RESP_OKAY : `SSSR_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // sssr_top
